//--- rtl/timer_if.sv
`timescale 1ns/1ps
interface timer_if #(parameter int W = 16);
   logic         start;
   logic [W-1:0] limit;
   logic         done;

   modport ctl (output start, output limit, input done);
   modport tmr (input start, input limit, output done);
endinterface

//--- rtl/trig_seq_defines.svh
`ifndef TRIG_SEQ_DEFINES_SVH
`define TRIG_SEQ_DEFINES_SVH

// Register byte offsets on the bus.
`define OFS_CONTROL      8'h00
`define OFS_COMMAND      8'h04
`define OFS_STATUS       8'h08
`define OFS_COUNTER0     8'h0c
`define OFS_COUNTER1     8'h10
`define OFS_LITERAL0     8'h14
`define OFS_C0_LIMIT     8'h18
`define OFS_C1_LIMIT     8'h1c
`define OFS_T0_LIMIT     8'h20
`define OFS_T1_LIMIT     8'h24
`define OFS_SD_LIMIT     8'h28
`define OFS_ADJUST       8'h2c
`define OFS_HOLD         8'h30
`define OFS_BCAST_EN     8'h34
`define OFS_CHAN_SEL     8'h38

// Control register fields.
`define CTL_SWT_BIT      0
`define CTL_SD_EN_BIT    1

// Status register fields.
`define STS_BUSY_BIT     0
`define STS_WAIT_T0_BIT  1
`define STS_WAIT_T1_BIT  2
`define STS_WAIT_SWT_BIT 3
`define STS_DELAY_BIT    4
`define STS_SD_EN_BIT    5
`define STS_DROP_BIT     6

// Step command word layout: code in [7:4], option in [3:0].
`define CMD_CODE_MSB     7
`define CMD_CODE_LSB     4
`define CMD_OPT_MSB      3
`define CMD_OPT_LSB      0

// Command codes.
`define CODE_CONTROL     4'h0
`define CODE_ADJUST_ADD  4'h1
`define CODE_HOLD_COPY   4'h2

// Control step options.
`define OPT_SD_DISABLE   4'h2
`define OPT_SD_ENABLE    4'h6
`define OPT_WAIT_T0      4'h8
`define OPT_WAIT_T1      4'h9
`define OPT_WAIT_SWT     4'hb
`define OPT_CHS_C0       4'hc
`define OPT_CHS_C1       4'hd
`define OPT_CHS_LIT0     4'he
`define OPT_BROADCAST    4'hf

// Adjust-add step options.
`define OPT_ADD_C0LIM    4'h0
`define OPT_ADD_C1LIM    4'h1
`define OPT_ADD_T0LIM    4'h2
`define OPT_ADD_T1LIM    4'h3
`define OPT_ADD_SDLIM    4'h4
`define OPT_ADD_LIT0     4'h5

// Hold-copy step options.
`define OPT_CPY_C0LIM    4'h8
`define OPT_CPY_C1LIM    4'h9
`define OPT_CPY_T0LIM    4'ha
`define OPT_CPY_T1LIM    4'hb
`define OPT_CPY_SDLIM    4'hc
`define OPT_CPY_LIT0     4'hd

// Reset values.
`define RST_REG16        16'h0000
`define RST_CMD          8'h00
`define RST_WORD         32'h0000_0000

`endif

//--- rtl/trig_seq_pkg.sv
package trig_seq_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      ST_IDLE     = 6'b000001,
      ST_EXEC     = 6'b000010,
      ST_WAIT_T0  = 6'b000100,
      ST_WAIT_T1  = 6'b001000,
      ST_WAIT_SWT = 6'b010000,
      ST_DELAY    = 6'b100000
   } seq_state_e;

   // Width of every limit, literal and counter register.
   typedef logic [15:0] word16_t;

endpackage

//--- rtl/trigger_step_sequencer_ops.sv
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "trig_seq_defines.svh"

module trigger_step_sequencer_ops #(
   parameter int NTRIG = 16
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Wishbone slave.
   input  wire logic             wb_cyc,
   input  wire logic             wb_stb,
   input  wire logic             wb_we,
   input  wire logic [7:0]       wb_adr,
   input  wire logic [3:0]       wb_sel,
   input  wire logic [31:0]      wb_dat_w,
   output logic      [31:0]      wb_dat_r,
   output logic                  wb_ack,
   // Peripheral side.
   output logic      [NTRIG-1:0] trig_out,
   output logic      [15:0]      adc_chan_sel,
   output logic                  busy
);

   timer_if #(.W(16)) t0_if ();
   timer_if #(.W(16)) t1_if ();
   timer_if #(.W(16)) sd_if ();

   wait_timer #(.W(16)) u_timer0 (.ref_clk(ref_clk), .rst_n(rst_n), .tmr(t0_if));
   wait_timer #(.W(16)) u_timer1 (.ref_clk(ref_clk), .rst_n(rst_n), .tmr(t1_if));
   wait_timer #(.W(16)) u_delay  (.ref_clk(ref_clk), .rst_n(rst_n), .tmr(sd_if));

   trig_seq_pkg::seq_state_e state_ff;
   trig_seq_pkg::seq_state_e nxt_state;
   trig_seq_pkg::word16_t    c0_ff, c1_ff, lit0_ff, c0lim_ff, c1lim_ff;
   trig_seq_pkg::word16_t    t0lim_ff, t1lim_ff, sdlim_ff, adj_ff, hold_ff, chs_ff;
   trig_seq_pkg::word16_t    nxt_c0, nxt_c1, nxt_lit0, nxt_c0lim, nxt_c1lim;
   trig_seq_pkg::word16_t    nxt_t0lim, nxt_t1lim, nxt_sdlim, nxt_adj, nxt_hold, nxt_chs;
   logic [NTRIG-1:0]         bte_ff, nxt_bte, trig_ff, nxt_trig;
   logic [7:0]               cmd_ff, nxt_cmd;
   logic                     sd_en_ff, nxt_sd_en, swt_ff, nxt_swt, swt_prev_ff;
   logic                     drop_ff, nxt_drop, ack_ff, nxt_ack;
   logic [31:0]              rdata_ff, nxt_rdata, rd_mux;
   logic                     req, wr, step_end;
   logic [3:0]               code, opt;

   assign req  = wb_cyc && wb_stb;
   // The write lands on the edge where the master sees ack, not before.
   assign wr   = req && wb_we && ack_ff;
   assign code = cmd_ff[`CMD_CODE_MSB:`CMD_CODE_LSB];
   assign opt  = cmd_ff[`CMD_OPT_MSB:`CMD_OPT_LSB];

   assign wb_ack       = ack_ff;
   assign wb_dat_r     = rdata_ff;
   assign trig_out     = trig_ff;
   assign adc_chan_sel = chs_ff;
   assign busy         = (state_ff != trig_seq_pkg::ST_IDLE);

   // Lane merge for 16-bit registers; lanes 2 and 3 are not stored.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0] = d[7:0];
      if (sel[1]) r[15:8] = d[15:8];
      return r;
   endfunction

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      rd_mux = `RST_WORD;
      case (wb_adr)
         `OFS_CONTROL: begin
            rd_mux[`CTL_SWT_BIT]   = swt_ff;
            rd_mux[`CTL_SD_EN_BIT] = sd_en_ff;
         end
         `OFS_COMMAND:  rd_mux[7:0]  = cmd_ff;
         `OFS_STATUS: begin
            rd_mux[`STS_BUSY_BIT]     = busy;
            rd_mux[`STS_WAIT_T0_BIT]  = (state_ff == trig_seq_pkg::ST_WAIT_T0);
            rd_mux[`STS_WAIT_T1_BIT]  = (state_ff == trig_seq_pkg::ST_WAIT_T1);
            rd_mux[`STS_WAIT_SWT_BIT] = (state_ff == trig_seq_pkg::ST_WAIT_SWT);
            rd_mux[`STS_DELAY_BIT]    = (state_ff == trig_seq_pkg::ST_DELAY);
            rd_mux[`STS_SD_EN_BIT]    = sd_en_ff;
            rd_mux[`STS_DROP_BIT]     = drop_ff;
         end
         `OFS_COUNTER0: rd_mux[15:0] = c0_ff;
         `OFS_COUNTER1: rd_mux[15:0] = c1_ff;
         `OFS_LITERAL0: rd_mux[15:0] = lit0_ff;
         `OFS_C0_LIMIT: rd_mux[15:0] = c0lim_ff;
         `OFS_C1_LIMIT: rd_mux[15:0] = c1lim_ff;
         `OFS_T0_LIMIT: rd_mux[15:0] = t0lim_ff;
         `OFS_T1_LIMIT: rd_mux[15:0] = t1lim_ff;
         `OFS_SD_LIMIT: rd_mux[15:0] = sdlim_ff;
         `OFS_ADJUST:   rd_mux[15:0] = adj_ff;
         `OFS_HOLD:     rd_mux[15:0] = hold_ff;
         `OFS_BCAST_EN: rd_mux[NTRIG-1:0] = bte_ff;
         `OFS_CHAN_SEL: rd_mux[15:0] = chs_ff;
         default:       rd_mux = `RST_WORD;
      endcase
   end

   // Bus handshake: data is captured in the first cycle and ack follows one cycle later.
   always_comb begin
      nxt_ack   = req && !ack_ff;
      nxt_rdata = (req && !ack_ff) ? rd_mux : rdata_ff;
   end

   // Timer limits follow the registers live, so a limit change during a wait moves the match.
   assign t0_if.limit = t0lim_ff;
   assign t1_if.limit = t1lim_ff;
   assign sd_if.limit = sdlim_ff;

   // Register file, command execution and sequencer state in one group, since a step
   // and a software write may touch the same register in one cycle; the step wins.
   always_comb begin
      nxt_state = state_ff;
      nxt_c0    = c0_ff;
      nxt_c1    = c1_ff;
      nxt_lit0  = lit0_ff;
      nxt_c0lim = c0lim_ff;
      nxt_c1lim = c1lim_ff;
      nxt_t0lim = t0lim_ff;
      nxt_t1lim = t1lim_ff;
      nxt_sdlim = sdlim_ff;
      nxt_adj   = adj_ff;
      nxt_hold  = hold_ff;
      nxt_bte   = bte_ff;
      nxt_chs   = chs_ff;
      nxt_cmd   = cmd_ff;
      nxt_sd_en = sd_en_ff;
      nxt_swt   = swt_ff;
      nxt_drop  = drop_ff;
      nxt_trig  = '0;
      step_end  = 1'b0;
      t0_if.start = 1'b0;
      t1_if.start = 1'b0;
      sd_if.start = 1'b0;

      // Software writes.
      if (wr) begin
         case (wb_adr)
            `OFS_CONTROL: begin
               if (wb_sel[0]) begin
                  nxt_swt   = wb_dat_w[`CTL_SWT_BIT];
                  nxt_sd_en = wb_dat_w[`CTL_SD_EN_BIT];
               end
            end
            `OFS_COMMAND: begin
               // A command is only taken while idle; otherwise it is dropped and flagged.
               if (state_ff == trig_seq_pkg::ST_IDLE && wb_sel[0]) begin
                  nxt_cmd   = wb_dat_w[7:0];
                  nxt_state = trig_seq_pkg::ST_EXEC;
               end else begin
                  nxt_drop = 1'b1;
               end
            end
            `OFS_STATUS:   nxt_drop  = drop_ff && !(wb_sel[0] && wb_dat_w[`STS_DROP_BIT]);
            `OFS_COUNTER0: nxt_c0    = merge(c0_ff, wb_dat_w, wb_sel);
            `OFS_COUNTER1: nxt_c1    = merge(c1_ff, wb_dat_w, wb_sel);
            `OFS_LITERAL0: nxt_lit0  = merge(lit0_ff, wb_dat_w, wb_sel);
            `OFS_C0_LIMIT: nxt_c0lim = merge(c0lim_ff, wb_dat_w, wb_sel);
            `OFS_C1_LIMIT: nxt_c1lim = merge(c1lim_ff, wb_dat_w, wb_sel);
            `OFS_T0_LIMIT: nxt_t0lim = merge(t0lim_ff, wb_dat_w, wb_sel);
            `OFS_T1_LIMIT: nxt_t1lim = merge(t1lim_ff, wb_dat_w, wb_sel);
            `OFS_SD_LIMIT: nxt_sdlim = merge(sdlim_ff, wb_dat_w, wb_sel);
            `OFS_ADJUST:   nxt_adj   = merge(adj_ff, wb_dat_w, wb_sel);
            `OFS_HOLD:     nxt_hold  = merge(hold_ff, wb_dat_w, wb_sel);
            `OFS_BCAST_EN: nxt_bte   = NTRIG'(merge(16'(bte_ff), wb_dat_w, wb_sel));
            default:       nxt_drop  = drop_ff;
         endcase
      end

      // Sequencer.
      case (state_ff)
         trig_seq_pkg::ST_IDLE: nxt_state = nxt_state;
         trig_seq_pkg::ST_EXEC: begin
            step_end = 1'b1;
            case (code)
               `CODE_CONTROL: begin
                  case (opt)
                     `OPT_SD_DISABLE: nxt_sd_en = 1'b0;
                     `OPT_SD_ENABLE:  nxt_sd_en = 1'b1;
                     `OPT_WAIT_T0: begin
                        t0_if.start = 1'b1;
                        step_end    = 1'b0;
                        nxt_state   = trig_seq_pkg::ST_WAIT_T0;
                     end
                     `OPT_WAIT_T1: begin
                        t1_if.start = 1'b1;
                        step_end    = 1'b0;
                        nxt_state   = trig_seq_pkg::ST_WAIT_T1;
                     end
                     `OPT_WAIT_SWT: begin
                        step_end  = 1'b0;
                        nxt_state = trig_seq_pkg::ST_WAIT_SWT;
                     end
                     `OPT_CHS_C0:   nxt_chs = c0_ff;
                     `OPT_CHS_C1:   nxt_chs = c1_ff;
                     `OPT_CHS_LIT0: nxt_chs = lit0_ff;
                     `OPT_BROADCAST: nxt_trig = bte_ff;
                     default: nxt_chs = chs_ff;
                  endcase
               end
               `CODE_ADJUST_ADD: begin
                  case (opt)
                     `OPT_ADD_C0LIM: nxt_c0lim = c0lim_ff + adj_ff;
                     `OPT_ADD_C1LIM: nxt_c1lim = c1lim_ff + adj_ff;
                     `OPT_ADD_T0LIM: nxt_t0lim = t0lim_ff + adj_ff;
                     `OPT_ADD_T1LIM: nxt_t1lim = t1lim_ff + adj_ff;
                     `OPT_ADD_SDLIM: nxt_sdlim = sdlim_ff + adj_ff;
                     `OPT_ADD_LIT0:  nxt_lit0  = lit0_ff + adj_ff;
                     default:        nxt_lit0  = nxt_lit0;
                  endcase
               end
               `CODE_HOLD_COPY: begin
                  case (opt)
                     `OPT_CPY_C0LIM: nxt_c0lim = hold_ff;
                     `OPT_CPY_C1LIM: nxt_c1lim = hold_ff;
                     `OPT_CPY_T0LIM: nxt_t0lim = hold_ff;
                     `OPT_CPY_T1LIM: nxt_t1lim = hold_ff;
                     `OPT_CPY_SDLIM: nxt_sdlim = hold_ff;
                     `OPT_CPY_LIT0:  nxt_lit0  = hold_ff;
                     default:        nxt_lit0  = nxt_lit0;
                  endcase
               end
               default: step_end = 1'b1;
            endcase
         end
         trig_seq_pkg::ST_WAIT_T0:  step_end = t0_if.done;
         trig_seq_pkg::ST_WAIT_T1:  step_end = t1_if.done;
         trig_seq_pkg::ST_WAIT_SWT: step_end = swt_ff && !swt_prev_ff;
         trig_seq_pkg::ST_DELAY:    nxt_state = sd_if.done ? trig_seq_pkg::ST_IDLE : state_ff;
         default:                   nxt_state = trig_seq_pkg::ST_IDLE;
      endcase

      // A finished step passes through the step delay when it is enabled.
      if (step_end) begin
         if (nxt_sd_en) begin
            sd_if.start = 1'b1;
            nxt_state   = trig_seq_pkg::ST_DELAY;
         end else begin
            nxt_state = trig_seq_pkg::ST_IDLE;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= trig_seq_pkg::ST_IDLE;
         c0_ff       <= `RST_REG16;
         c1_ff       <= `RST_REG16;
         lit0_ff     <= `RST_REG16;
         c0lim_ff    <= `RST_REG16;
         c1lim_ff    <= `RST_REG16;
         t0lim_ff    <= `RST_REG16;
         t1lim_ff    <= `RST_REG16;
         sdlim_ff    <= `RST_REG16;
         adj_ff      <= `RST_REG16;
         hold_ff     <= `RST_REG16;
         chs_ff      <= `RST_REG16;
         bte_ff      <= '0;
         trig_ff     <= '0;
         cmd_ff      <= `RST_CMD;
         sd_en_ff    <= 1'b0;
         swt_ff      <= 1'b0;
         swt_prev_ff <= 1'b0;
         drop_ff     <= 1'b0;
         ack_ff      <= 1'b0;
         rdata_ff    <= `RST_WORD;
      end else begin
         state_ff    <= nxt_state;
         c0_ff       <= nxt_c0;
         c1_ff       <= nxt_c1;
         lit0_ff     <= nxt_lit0;
         c0lim_ff    <= nxt_c0lim;
         c1lim_ff    <= nxt_c1lim;
         t0lim_ff    <= nxt_t0lim;
         t1lim_ff    <= nxt_t1lim;
         sdlim_ff    <= nxt_sdlim;
         adj_ff      <= nxt_adj;
         hold_ff     <= nxt_hold;
         chs_ff      <= nxt_chs;
         bte_ff      <= nxt_bte;
         trig_ff     <= nxt_trig;
         cmd_ff      <= nxt_cmd;
         sd_en_ff    <= nxt_sd_en;
         swt_ff      <= nxt_swt;
         swt_prev_ff <= swt_ff;
         drop_ff     <= nxt_drop;
         ack_ff      <= nxt_ack;
         rdata_ff    <= nxt_rdata;
      end
   end

endmodule

//--- rtl/wait_timer.sv
`timescale 1ns/1ps
module wait_timer #(
   parameter int W = 16
) (
   // Clock and reset.
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Control side.
   timer_if.tmr      tmr
);

   logic [W-1:0] count_ff;
   logic [W-1:0] nxt_count;
   logic         running_ff;
   logic         nxt_running;

   // Done is combinational so the sequencer leaves its wait in the match cycle.
   assign tmr.done = running_ff && (count_ff == tmr.limit);

   // A start restarts from zero; the timer stops itself on the match.
   always_comb begin
      nxt_count   = count_ff;
      nxt_running = running_ff;
      if (tmr.start) begin
         nxt_count   = '0;
         nxt_running = 1'b1;
      end else if (tmr.done) begin
         nxt_running = 1'b0;
      end else if (running_ff) begin
         nxt_count = count_ff + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff   <= '0;
         running_ff <= 1'b0;
      end else begin
         count_ff   <= nxt_count;
         running_ff <= nxt_running;
      end
   end

endmodule

//--- tb/periph_model.sv
`timescale 1ns/1ps
// Stands for the peripherals that take the trigger pulses.
module periph_model #(
   parameter int NTRIG = 16
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // From the sequencer.
   input  wire logic [NTRIG-1:0] trig_out,
   // Observations.
   output logic      [NTRIG-1:0] trig_last,
   output int                    pulse_cnt
);
   // A peripheral cannot refuse a pulse, so every active cycle is counted.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_last <= '0;
         pulse_cnt <= 0;
      end else if (trig_out != '0) begin
         trig_last <= trig_out;
         pulse_cnt <= pulse_cnt + 1;
      end
   end
endmodule

//--- tb/trig_seq_checker.sv
`timescale 1ns/1ps
// Watches the bus handshake and the step outputs from the top ports only.
module trig_seq_checker #(
   parameter int NTRIG = 16
) (
   // Clock and reset.
   input wire logic             ref_clk,
   input wire logic             rst_n,
   // Bus.
   input wire logic             wb_cyc,
   input wire logic             wb_stb,
   input wire logic             wb_we,
   input wire logic [7:0]       wb_adr,
   input wire logic [3:0]       wb_sel,
   input wire logic [31:0]      wb_dat_w,
   input wire logic [31:0]      wb_dat_r,
   input wire logic             wb_ack,
   // Peripheral side.
   input wire logic [NTRIG-1:0] trig_out,
   input wire logic [15:0]      adc_chan_sel,
   input wire logic             busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // A step command taken while idle; a busy write is dropped instead.
   sequence s_cmd;
      wb_cyc && wb_stb && wb_we && wb_ack && wb_adr == 8'h04 && wb_sel[0] && !busy;
   endsequence
   sequence s_nop_cmd;
      s_cmd ##0 (wb_dat_w[7:4] > 4'h2);
   endsequence

   property p_ack_one;
      wb_cyc && wb_stb && !wb_ack |=> wb_ack;
   endproperty
   property p_ack_pulse;
      wb_ack |=> !wb_ack;
   endproperty
   property p_ack_cause;
      !(wb_cyc && wb_stb) |=> !wb_ack;
   endproperty
   property p_exec;
      s_cmd |=> busy;
   endproperty
   property p_trig_once;
      trig_out != '0 |=> trig_out == '0;
   endproperty
   property p_trig_cause;
      trig_out != '0 |-> $past(busy);
   endproperty
   property p_chan_cause;
      $changed(adc_chan_sel) |-> $past(busy);
   endproperty
   // Effects land two samples after the commit, so that is where a nop must stay quiet.
   property p_nop;
      s_nop_cmd |-> ##2 (trig_out == '0 && $stable(adc_chan_sel));
   endproperty

   a_ack_one: assert property (p_ack_one) else $error("ack missing after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_exec: assert property (p_exec) else $error("step not started");
   a_trig_once: assert property (p_trig_once) else $error("trigger not a pulse");
   a_trig_cause: assert property (p_trig_cause) else $error("trigger without step");
   a_chan_cause: assert property (p_chan_cause) else $error("channel without step");
   a_nop: assert property (p_nop) else $error("reserved step had an effect");
endmodule

bind trigger_step_sequencer_ops trig_seq_checker #(.NTRIG(NTRIG)) chk_u (
   .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
   .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
   .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .trig_out(trig_out),
   .adc_chan_sel(adc_chan_sel), .busy(busy));

//--- tb/trigger_step_sequencer_ops_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module trigger_step_sequencer_ops_test;
   logic        ref_clk;
   logic        rst_n;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic [15:0] trig_out;
   logic [15:0] adc_chan_sel;
   logic        busy;
   logic [15:0] trig_last;
   int          pulse_cnt;
   int          fail_count;
   int          cmp_count;
   int          cyc_count;
   logic [31:0] rd;
   logic [7:0]  dst [6] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h14};

   trigger_step_sequencer_ops #(.NTRIG(16)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .trig_out(trig_out),
      .adc_chan_sel(adc_chan_sel), .busy(busy));
   periph_model #(.NTRIG(16)) model_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .trig_out(trig_out),
      .trig_last(trig_last), .pulse_cnt(pulse_cnt));

   // Free-running 50 ns clock.
   always #25 ref_clk = ~ref_clk;

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // A hung handshake would stall forever, so a cycle ceiling ends the run.
   always @(posedge ref_clk) begin
      cyc_count++;
      if (cyc_count == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end

   // One classic cycle; read data is taken at the edge where ack is seen.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= w;
      wb_sel   <= 4'h3;
      wb_adr   <= a;
      wb_dat_w <= d;
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rd)
   endtask

   // Counts edges that still see busy, so the figure is the step length.
   task automatic wait_idle(output int n);
      n = 0;
      repeat (300) begin
         @(posedge ref_clk);
         if (busy !== 1'b1) break;
         n++;
      end
   endtask

   task automatic step(input logic [7:0] c, input int e);
      int n;
      bus(1'b1, 8'h04, {24'h0, c});
      wait_idle(n);
      `CHK($sformatf("busy cycles %h", c), e, n)
   endtask

   task automatic t_regs;
      chk_rd(8'h18, 32'h0);
      bus(1'b1, 8'h38, 32'hffff);
      chk_rd(8'h38, 32'h0);
      bus(1'b1, 8'h3c, 32'h1234);
      chk_rd(8'h3c, 32'h0);
      bus(1'b1, 8'h2c, 32'hffff_0005);
      chk_rd(8'h2c, 32'h5);
      `CHK("chan sel port", 16'h0, adc_chan_sel)
      $display("test regs done");
   endtask

   task automatic t_ops;
      logic [7:0] nop [4] = '{8'h16, 8'h17, 8'h2e, 8'h2f};
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, dst[i], 32'hfffe);
         step(8'h10 + i[7:0], 1);
         chk_rd(dst[i], 32'h0003);
      end
      for (int i = 0; i < 4; i++) step(nop[i], 1);
      for (int i = 0; i < 6; i++) chk_rd(dst[i], 32'h0003);
      bus(1'b1, 8'h30, 32'h5a3c);
      for (int i = 0; i < 6; i++) begin
         step(8'h28 + i[7:0], 1);
         chk_rd(dst[i], 32'h5a3c);
      end
      $display("test ops done");
   endtask

   task automatic t_chan;
      bus(1'b1, 8'h0c, 32'h0011);
      bus(1'b1, 8'h10, 32'h0022);
      bus(1'b1, 8'h14, 32'h0033);
      for (int i = 0; i < 3; i++) begin
         step(8'h0c + i[7:0], 1);
         `CHK("chan sel port", 16'h0011 * (i + 1), adc_chan_sel)
         chk_rd(8'h38, 16'h0011 * (i + 1));
      end
      $display("test chan done");
   endtask

   task automatic t_bcast;
      int n0;
      bus(1'b1, 8'h34, 32'ha5c3);
      n0 = pulse_cnt;
      step(8'h0f, 1);
      @(posedge ref_clk);
      `CHK("trigger seen", 16'ha5c3, trig_last)
      `CHK("pulse count", n0 + 1, pulse_cnt)
      $display("test bcast done");
   endtask

   task automatic t_wait;
      int n;
      bus(1'b1, 8'h20, 32'd10);
      step(8'h08, 12);
      // A status read in mid-wait must show the timer 0 wait, then the rest of it runs out.
      bus(1'b1, 8'h04, 32'h08);
      chk_rd(8'h08, 32'h03);
      wait_idle(n);
      `CHK("t0 rest", 9, n)
      bus(1'b1, 8'h20, 32'd0);
      step(8'h08, 2);
      bus(1'b1, 8'h24, 32'd5);
      step(8'h09, 7);
      $display("test wait done");
   endtask

   task automatic t_delay;
      bus(1'b1, 8'h28, 32'd4);
      step(8'h06, 6);
      chk_rd(8'h08, 32'h20);
      chk_rd(8'h00, 32'h2);
      step(8'h30, 6);
      step(8'h02, 1);
      step(8'h01, 1);
      $display("test delay done");
   endtask

   // An edge made before the wait must not release it, and a busy write is dropped.
   task automatic t_swt;
      int n;
      int n0;
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h04, 32'h0b);
      repeat (10) @(posedge ref_clk);
      `CHK("swt held", 1'b1, busy)
      n0 = pulse_cnt;
      bus(1'b1, 8'h04, 32'h0f);
      chk_rd(8'h08, 32'h49);
      bus(1'b1, 8'h08, 32'h40);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, 32'h1);
      wait_idle(n);
      `CHK("swt released", 1, n)
      `CHK("dropped pulse", n0, pulse_cnt)
      chk_rd(8'h08, 32'h0);
      $display("test swt done");
   endtask

   // Reset, then the scenarios in order; delay stays off until the delay test.
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_w = 32'h0;
      fail_count = 0;
      cmp_count = 0;
      cyc_count = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_ops();
      t_chan();
      t_bcast();
      t_wait();
      t_delay();
      t_swt();
      report_and_stop();
   end
endmodule
